// ### rtl/sound_reg_interface.sv
// User register file of the TV sound processor behind the serial byte interface
`timescale 1ns/1ns
module sound_reg_interface
	import sound_regs_pkg::*;
#(
	parameter int   DETECT_LIMIT = DETECT_CYCLES,
	parameter logic DUAL_FM_OK   = 1'b1,
	parameter logic NICAM_OK     = 1'b1,
	parameter logic MTS_OK       = 1'b1
) (
	// Clock and reset
	input  wire logic           ref_clk_i,
	input  wire logic           reset_i,
	// Byte interface from the serial bus framer
	input  wire logic           frame_start_i,
	input  wire logic           frame_stop_i,
	input  wire logic           wr_byte_valid_i,
	input  wire logic [7:0]     wr_byte_i,
	output logic                wr_byte_ack_o,
	input  wire logic           rd_byte_req_i,
	output logic      [7:0]     rd_byte_o,
	output logic                rd_byte_valid_o,
	// Demodulator and measurement inputs
	input  wire logic           scan_done_i,
	input  wire logic [15:0]    scan_code_i,
	input  wire logic [15:0]    reception_status_i,
	input  wire logic [15:0]    peak_left_i,
	input  wire logic [15:0]    peak_right_i,
	// Control outputs
	output logic                scan_start_o,
	output logic                demod_init_o,
	output demod_ctrl_s         demod_ctrl_o,
	output baseband_ctrl_s      baseband_ctrl_o
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_SUB, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_HI, ST_DATA_LO, ST_DROP
	} byte_state_e;

	byte_state_e state_reg;
	logic [7:0]  sub_reg;
	logic [15:0] addr_reg;
	logic [7:0]  data_hi_reg;
	logic        read_armed_reg;
	logic        commit;
	logic [15:0] commit_data;
	logic [4:0]  commit_slot;
	logic        std_wr;
	logic        read_load;
	logic [15:0] read_word;
	logic [15:0] options_reg;
	logic [15:0] serial_cfg_reg;
	logic [15:0] status_reg;
	logic [15:0] bb_reg [0:BB_COUNT-1];
	logic [15:0] active_std;
	logic [15:0] std_family;
	logic        stereo_allowed;
	logic        detect_busy;
	logic [15:0] detect_result;

	// Subaddress classes
	function automatic logic is_write_sub(input logic [7:0] sub);
		return (sub == SUB_WR_DEMOD) || (sub == SUB_WR_BASEBAND);
	endfunction : is_write_sub

	function automatic logic is_read_sub(input logic [7:0] sub);
		return (sub == SUB_RD_DEMOD) || (sub == SUB_RD_BASEBAND);
	endfunction : is_read_sub

	// Peak readout limited to the non-negative range
	function automatic logic [15:0] peak_clip(input logic [15:0] level);
		return level[15] ? 16'h0000 : level;
	endfunction : peak_clip

	// Byte sequencing: subaddress, address high/low, data high/low
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			state_reg <= ST_IDLE;
		else if (frame_stop_i)
			state_reg <= ST_IDLE;
		else if (frame_start_i)
			state_reg <= read_armed_reg ? ST_DROP : ST_SUB;
		else if (wr_byte_valid_i) begin
			case (state_reg)
				ST_SUB: begin
					if (is_write_sub(wr_byte_i) || is_read_sub(wr_byte_i))
						state_reg <= ST_ADDR_HI;
					else
						state_reg <= ST_DROP;
				end
				ST_ADDR_HI: state_reg <= ST_ADDR_LO;
				ST_ADDR_LO: state_reg <= is_write_sub(sub_reg) ? ST_DATA_HI : ST_DROP;
				ST_DATA_HI: state_reg <= ST_DATA_LO;
				ST_DATA_LO: state_reg <= ST_DROP;
				default: state_reg <= state_reg;
			endcase
		end
	end

	// Address and upper data byte capture, upper byte first
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sub_reg     <= 8'h00;
			addr_reg    <= 16'h0000;
			data_hi_reg <= 8'h00;
		end else if (wr_byte_valid_i && !frame_start_i && !frame_stop_i) begin
			case (state_reg)
				ST_SUB: sub_reg <= wr_byte_i;
				ST_ADDR_HI: addr_reg[15:8] <= wr_byte_i;
				ST_ADDR_LO: addr_reg[7:0] <= wr_byte_i;
				ST_DATA_HI: data_hi_reg <= wr_byte_i;
				default: data_hi_reg <= data_hi_reg;
			endcase
		end
	end

	// Read address is armed for the repeated start that follows
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			read_armed_reg <= 1'b0;
		else if (frame_start_i || frame_stop_i)
			read_armed_reg <= 1'b0;
		else if (wr_byte_valid_i && state_reg == ST_ADDR_LO)
			read_armed_reg <= is_read_sub(sub_reg);
	end

	// Byte acknowledge; bytes past the word or to unknown subaddresses are refused
	always_comb begin
		case (state_reg)
			ST_SUB: wr_byte_ack_o = is_write_sub(wr_byte_i) || is_read_sub(wr_byte_i);
			ST_ADDR_HI, ST_ADDR_LO, ST_DATA_HI, ST_DATA_LO: wr_byte_ack_o = 1'b1;
			default: wr_byte_ack_o = 1'b0;
		endcase
	end

	// Word commit on the lower data byte
	assign commit      = wr_byte_valid_i && !frame_start_i && !frame_stop_i
	                     && state_reg == ST_DATA_LO;
	assign commit_data = {data_hi_reg, wr_byte_i};
	assign commit_slot = bb_slot(addr_reg);

	// Mode and standard writes are held off while detection runs
	assign std_wr = commit && sub_reg == SUB_WR_DEMOD && addr_reg == ADDR_STD_SELECT
	                && !detect_busy;

	// Demodulator write bank
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			options_reg    <= WORD_RESET;
			serial_cfg_reg <= WORD_RESET;
		end else if (commit && sub_reg == SUB_WR_DEMOD) begin
			if (addr_reg == ADDR_DEMOD_OPT && !detect_busy)
				options_reg <= commit_data;
			else if (addr_reg == ADDR_SERIAL_CFG)
				serial_cfg_reg <= commit_data;
		end
	end

	// Baseband read/write bank; read-only addresses have no slot
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < BB_COUNT; i++)
				bb_reg[i] <= bb_reset(i);
		end else if (commit && sub_reg == SUB_WR_BASEBAND && commit_slot != BB_NONE)
			bb_reg[commit_slot] <= commit_data;
	end

	// Status is frozen while detection runs and refreshed once it ends
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			status_reg <= WORD_RESET;
		else if (!detect_busy)
			status_reg <= reception_status_i;
	end

	// Read word selection; demodulator write registers are absent here
	always_comb begin
		read_word = 16'h0000;
		if (sub_reg == SUB_RD_DEMOD) begin
			case (addr_reg)
				ADDR_DETECT_RES: read_word = detect_result;
				ADDR_RX_STATUS: read_word = status_reg;
				default: read_word = 16'h0000;
			endcase
		end else if (sub_reg == SUB_RD_BASEBAND) begin
			case (addr_reg)
				ADDR_PEAK_LEFT: read_word = peak_clip(peak_left_i);
				ADDR_PEAK_RIGHT: read_word = peak_clip(peak_right_i);
				ADDR_HW_VERSION: read_word = HW_VERSION_ID;
				ADDR_PRODUCT_ROM: read_word = PRODUCT_ROM_ID;
				default: read_word = (commit_slot != BB_NONE) ? bb_reg[commit_slot] : 16'h0000;
			endcase
		end
	end

	// The word is captured at the repeated start so both bytes belong together
	assign read_load = frame_start_i && read_armed_reg;

	word_byte_serializer read_port (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.load_i       (read_load),
		.word_i       (read_word),
		.byte_req_i   (rd_byte_req_i),
		.byte_o       (rd_byte_o),
		.byte_valid_o (rd_byte_valid_o)
	);

	std_select_engine #(
		.DETECT_LIMIT (DETECT_LIMIT),
		.DUAL_FM_OK   (DUAL_FM_OK),
		.NICAM_OK     (NICAM_OK),
		.MTS_OK       (MTS_OK)
	) std_engine (
		.ref_clk_i        (ref_clk_i),
		.reset_i          (reset_i),
		.std_wr_i         (std_wr),
		.std_code_i       (commit_data),
		.auto_sound_i     (options_reg[OPT_AUTO_SOUND]),
		.scan_start_o     (scan_start_o),
		.scan_done_i      (scan_done_i),
		.scan_code_i      (scan_code_i),
		.demod_init_o     (demod_init_o),
		.active_std_o     (active_std),
		.std_family_o     (std_family),
		.stereo_allowed_o (stereo_allowed),
		.busy_o           (detect_busy),
		.result_o         (detect_result)
	);

	// Demodulator setup outputs
	assign demod_ctrl_o.demod_options       = options_reg;
	assign demod_ctrl_o.serial_audio_config = serial_cfg_reg;
	assign demod_ctrl_o.active_std          = active_std;
	assign demod_ctrl_o.std_family          = std_family;
	assign demod_ctrl_o.stereo_allowed      = stereo_allowed;
	assign demod_ctrl_o.detect_busy         = detect_busy;
	assign demod_ctrl_o.detection_result    = detect_result;

	// Baseband control outputs in slot order
	assign baseband_ctrl_o.speaker_volume         = bb_reg[0];
	assign baseband_ctrl_o.speaker_balance        = bb_reg[1];
	assign baseband_ctrl_o.speaker_bass           = bb_reg[2];
	assign baseband_ctrl_o.speaker_treble         = bb_reg[3];
	assign baseband_ctrl_o.speaker_loudness       = bb_reg[4];
	assign baseband_ctrl_o.speaker_spatial_effect = bb_reg[5];
	assign baseband_ctrl_o.line_out_volume        = bb_reg[6];
	assign baseband_ctrl_o.speaker_route          = bb_reg[7];
	assign baseband_ctrl_o.line_out_route         = bb_reg[8];
	assign baseband_ctrl_o.serial_audio_out_route = bb_reg[9];
	assign baseband_ctrl_o.peak_detector_route    = bb_reg[10];
	assign baseband_ctrl_o.line_in_prescale       = bb_reg[11];
	assign baseband_ctrl_o.fm_am_prescale_matrix  = bb_reg[12];
	assign baseband_ctrl_o.digital_sound_prescale = bb_reg[13];
	assign baseband_ctrl_o.serial_in2_prescale    = bb_reg[14];
	assign baseband_ctrl_o.switch_and_pin_control = bb_reg[15];
	assign baseband_ctrl_o.beep_generator         = bb_reg[16];
	assign baseband_ctrl_o.serial_in1_prescale    = bb_reg[17];
	assign baseband_ctrl_o.auto_volume_correction = bb_reg[18];

endmodule : sound_reg_interface

// ### rtl/sound_regs_pkg.sv
// Shared constants, types and helpers of the sound processor register interface
package sound_regs_pkg;

	// Clock and detection time limit
	localparam int          CLK_FREQ_HZ      = 50_000_000;
	localparam int          DETECT_LIMIT_MS  = 500;
	localparam int          DETECT_CYCLES    = (CLK_FREQ_HZ / 1000) * DETECT_LIMIT_MS;

	// Bus subaddresses
	localparam logic [7:0]  SUB_WR_DEMOD     = 8'h10;
	localparam logic [7:0]  SUB_RD_DEMOD     = 8'h11;
	localparam logic [7:0]  SUB_WR_BASEBAND  = 8'h12;
	localparam logic [7:0]  SUB_RD_BASEBAND  = 8'h13;

	// Demodulator bank addresses
	localparam logic [15:0] ADDR_STD_SELECT  = 16'h0020;
	localparam logic [15:0] ADDR_DEMOD_OPT   = 16'h0030;
	localparam logic [15:0] ADDR_SERIAL_CFG  = 16'h0040;
	localparam logic [15:0] ADDR_DETECT_RES  = 16'h007e;
	localparam logic [15:0] ADDR_RX_STATUS   = 16'h0200;

	// Baseband bank read-only addresses
	localparam logic [15:0] ADDR_PEAK_LEFT   = 16'h0019;
	localparam logic [15:0] ADDR_PEAK_RIGHT  = 16'h001a;
	localparam logic [15:0] ADDR_HW_VERSION  = 16'h001e;
	localparam logic [15:0] ADDR_PRODUCT_ROM = 16'h001f;

	// Baseband read/write slots, in address order
	localparam int          BB_COUNT         = 19;
	localparam logic [4:0]  BB_NONE          = 5'h1f;
	localparam logic [15:0] BB_ADDR [0:BB_COUNT-1] = '{
		16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007,
		16'h0008, 16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h0010,
		16'h0012, 16'h0013, 16'h0014, 16'h0016, 16'h0029};

	// Field positions and reset values
	localparam int          HI_MSB           = 15;
	localparam int          HI_LSB           = 8;
	localparam logic [7:0]  VOLUME_MUTE      = 8'h00;
	localparam logic [7:0]  SRC_FM_AM        = 8'h00;
	localparam logic [7:0]  MAT_FIRST_SOUND  = 8'h00;
	localparam logic [15:0] ROUTE_RESET      = {SRC_FM_AM, MAT_FIRST_SOUND};
	localparam logic [15:0] SERIAL_PRE_RESET = 16'h1000;
	localparam logic [15:0] WORD_RESET       = 16'h0000;
	localparam int          OPT_AUTO_SOUND   = 0;

	// Standard codes
	localparam logic [15:0] STD_NONE         = 16'h0000;
	localparam logic [15:0] STD_AUTO         = 16'h0001;
	localparam logic [15:0] STD_BUSY         = 16'h0800;

	// Identification words, values arbitrary
	localparam logic [15:0] HW_VERSION_ID    = 16'h0101;
	localparam logic [15:0] PRODUCT_ROM_ID   = 16'h0201;

	// Baseband control carried out to the audio path
	typedef struct packed {
		logic [15:0] speaker_volume;
		logic [15:0] speaker_balance;
		logic [15:0] speaker_bass;
		logic [15:0] speaker_treble;
		logic [15:0] speaker_loudness;
		logic [15:0] speaker_spatial_effect;
		logic [15:0] line_out_volume;
		logic [15:0] speaker_route;
		logic [15:0] line_out_route;
		logic [15:0] serial_audio_out_route;
		logic [15:0] peak_detector_route;
		logic [15:0] line_in_prescale;
		logic [15:0] fm_am_prescale_matrix;
		logic [15:0] digital_sound_prescale;
		logic [15:0] serial_in2_prescale;
		logic [15:0] switch_and_pin_control;
		logic [15:0] beep_generator;
		logic [15:0] serial_in1_prescale;
		logic [15:0] auto_volume_correction;
	} baseband_ctrl_s;

	// Demodulator setup carried out to the demodulator
	typedef struct packed {
		logic [15:0] demod_options;
		logic [15:0] serial_audio_config;
		logic [15:0] active_std;
		logic [15:0] std_family;
		logic        stereo_allowed;
		logic        detect_busy;
		logic [15:0] detection_result;
	} demod_ctrl_s;

	// Slot of a baseband read/write address, BB_NONE if absent
	function automatic logic [4:0] bb_slot(input logic [15:0] addr);
		logic [4:0] slot;
		slot = BB_NONE;
		for (int i = 0; i < BB_COUNT; i++) begin
			if (BB_ADDR[i] == addr)
				slot = 5'(i);
		end
		return slot;
	endfunction : bb_slot

	// Reset value of a baseband slot
	function automatic logic [15:0] bb_reset(input int slot);
		case (BB_ADDR[slot])
			16'h0008, 16'h000a, 16'h000b, 16'h000c: return ROUTE_RESET;
			16'h0012, 16'h0016: return SERIAL_PRE_RESET;
			16'h0000: return {VOLUME_MUTE, 8'h00};
			default: return WORD_RESET;
		endcase
	endfunction : bb_reset

	// Listed standard codes
	function automatic logic std_listed(input logic [15:0] code);
		case (code)
			16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
			16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d,
			16'h0020, 16'h0021, 16'h0030, 16'h0040, 16'h0050, 16'h0051,
			16'h0060: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : std_listed

	// High deviation codes that detection never reports
	function automatic logic std_high_dev(input logic [15:0] code);
		return (code == 16'h000c) || (code == 16'h000d) || (code == 16'h0006);
	endfunction : std_high_dev

endpackage : sound_regs_pkg

// ### rtl/std_select_engine.sv
// Standard selection and automatic standard detection sequencing
`timescale 1ns/1ns
module std_select_engine
	import sound_regs_pkg::*;
#(
	parameter int   DETECT_LIMIT = DETECT_CYCLES,
	parameter logic DUAL_FM_OK   = 1'b1,
	parameter logic NICAM_OK     = 1'b1,
	parameter logic MTS_OK       = 1'b1
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Register side
	input  wire logic        std_wr_i,
	input  wire logic [15:0] std_code_i,
	input  wire logic        auto_sound_i,
	// Carrier scanner
	output logic             scan_start_o,
	input  wire logic        scan_done_i,
	input  wire logic [15:0] scan_code_i,
	// Demodulator setup
	output logic             demod_init_o,
	output logic      [15:0] active_std_o,
	output logic      [15:0] std_family_o,
	output logic             stereo_allowed_o,
	output logic             busy_o,
	output logic      [15:0] result_o
);

	typedef enum logic [0:0] {ENG_IDLE, ENG_SEARCH} eng_state_e;

	eng_state_e  state_reg;
	logic [24:0] timer_reg;

	// Stereo support of the variant; unsupported stereo falls back to mono
	function automatic logic stereo_ok(input logic [15:0] code);
		case (code)
			16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007: return DUAL_FM_OK;
			16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d: return NICAM_OK;
			16'h0020, 16'h0021, 16'h0030, 16'h0040: return MTS_OK;
			16'h0051: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : stereo_ok

	// Search sequencing, timer and result
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_reg    <= ENG_IDLE;
			timer_reg    <= '0;
			result_o     <= STD_NONE;
			active_std_o <= STD_NONE;
			demod_init_o <= 1'b0;
			scan_start_o <= 1'b0;
		end else begin
			demod_init_o <= 1'b0;
			scan_start_o <= 1'b0;
			if (std_wr_i) begin
				demod_init_o <= 1'b1;
				if (std_code_i == STD_AUTO) begin
					state_reg    <= ENG_SEARCH;
					timer_reg    <= '0;
					result_o     <= STD_BUSY;
					scan_start_o <= 1'b1;
				end else begin
					state_reg    <= ENG_IDLE;
					active_std_o <= std_listed(std_code_i) ? std_code_i : STD_NONE;
				end
			end else if (state_reg == ENG_SEARCH) begin
				timer_reg <= timer_reg + 25'd1;
				if (scan_done_i) begin
					state_reg <= ENG_IDLE;
					if (std_listed(scan_code_i) && !std_high_dev(scan_code_i)) begin
						result_o     <= scan_code_i;
						active_std_o <= scan_code_i;
						demod_init_o <= 1'b1;
					end else
						result_o <= STD_NONE;
				end else if (timer_reg >= 25'(DETECT_LIMIT - 1)) begin
					state_reg <= ENG_IDLE;
					result_o  <= STD_NONE;
				end
			end
		end
	end

	// Equivalent groups under automatic sound selection
	always_comb begin
		std_family_o = active_std_o;
		if (auto_sound_i) begin
			case (active_std_o)
				16'h0008: std_family_o = 16'h0003;
				16'h0005, 16'h0007, 16'h000b: std_family_o = 16'h0004;
				default: std_family_o = active_std_o;
			endcase
		end
	end

	assign stereo_allowed_o = stereo_ok(active_std_o);
	assign busy_o           = (state_reg == ENG_SEARCH);

endmodule : std_select_engine

// ### rtl/word_byte_serializer.sv
// Splits a 16-bit read word into two bytes, upper byte first
`timescale 1ns/1ns
module word_byte_serializer
	import sound_regs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Word side
	input  wire logic        load_i,
	input  wire logic [15:0] word_i,
	// Byte side
	input  wire logic        byte_req_i,
	output logic      [7:0]  byte_o,
	output logic             byte_valid_o
);

	logic        low_next_reg;
	logic [15:0] word_reg;

	// Word capture; a later request for the same word returns it again
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			word_reg <= WORD_RESET;
		else if (load_i)
			word_reg <= word_i;
	end

	// Byte phase and output
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			low_next_reg <= 1'b0;
			byte_o       <= 8'h00;
			byte_valid_o <= 1'b0;
		end else begin
			byte_valid_o <= byte_req_i & ~load_i;
			if (load_i)
				low_next_reg <= 1'b0;
			else if (byte_req_i) begin
				byte_o       <= low_next_reg ? word_reg[7:0] : word_reg[15:8];
				low_next_reg <= ~low_next_reg;
			end
		end
	end

endmodule : word_byte_serializer

// ### tb/carrier_scanner_model.sv
// Carrier scanner stand-in answering scan requests after a chosen delay
`timescale 1ns/1ns
module carrier_scanner_model (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Control from the bench
	input  wire logic        scan_start_i,
	input  wire logic        silent_i,
	input  wire logic [7:0]  delay_i,
	input  wire logic [15:0] found_code_i,
	// Answer to the design
	output logic             scan_done_o,
	output logic      [15:0] scan_code_o
);
	int wait_cnt;
	initial begin
		scan_done_o = 1'b0;
		scan_code_o = 16'h0000;
		wait_cnt = 0;
	end
	// Code lines toggle between answers so a stale code is never mistaken for a fresh one
	always @(negedge ref_clk_i) begin
		scan_done_o <= 1'b0;
		scan_code_o <= ~scan_code_o;
		if (reset_i)
			wait_cnt <= 0;
		else if (scan_start_i)
			wait_cnt <= delay_i;
		else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
			if (wait_cnt == 1 && !silent_i) begin
				scan_done_o <= 1'b1;
				scan_code_o <= found_code_i;
			end
		end
	end
endmodule : carrier_scanner_model

// ### tb/sound_reg_monitor.sv
// Port-level assertions for the sound register interface
`timescale 1ns/1ns
module sound_reg_monitor
	import sound_regs_pkg::*;
#(
	parameter int DETECT_LIMIT = DETECT_CYCLES
) (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	// Byte interface
	input wire logic        frame_start_i,
	input wire logic        rd_byte_req_i,
	input wire logic        rd_byte_valid_o,
	// Demodulator side
	input wire logic        scan_start_o,
	input wire logic        demod_init_o,
	input wire demod_ctrl_s demod_ctrl_o
);
	int busy_cnt;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// Length of the current detection run; a stuck busy flag shows up here
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !demod_ctrl_o.detect_busy)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	AST_RD_ANSWER: assert property (rd_byte_req_i && !frame_start_i |=> rd_byte_valid_o)
		else $error("read byte not answered");
	AST_RD_QUIET: assert property (!rd_byte_req_i |=> !rd_byte_valid_o)
		else $error("read byte without request");
	AST_SCAN_BUSY: assert property (scan_start_o |-> demod_ctrl_o.detect_busy
		&& demod_ctrl_o.detection_result == STD_BUSY) else $error("scan start without busy");
	AST_BUSY_RESULT: assert property (demod_ctrl_o.detect_busy
		|-> demod_ctrl_o.detection_result > 16'h07ff) else $error("busy result too low");
	AST_DETECT_BOUND: assert property (busy_cnt <= DETECT_LIMIT + 2)
		else $error("detection ran too long");
	AST_NO_HIGH_DEV: assert property ($fell(demod_ctrl_o.detect_busy) |->
		!(demod_ctrl_o.detection_result inside {16'h0006, 16'h000c, 16'h000d}))
		else $error("detection gave high deviation code");
	AST_APPLY: assert property ($fell(demod_ctrl_o.detect_busy)
		&& demod_ctrl_o.detection_result != STD_NONE
		|-> demod_ctrl_o.active_std == demod_ctrl_o.detection_result) else $error("not applied");
	AST_INIT_AFTER: assert property ($fell(demod_ctrl_o.detect_busy)
		&& demod_ctrl_o.detection_result != STD_NONE |-> ##[0:1] demod_init_o)
		else $error("no reinit after detection");
	AST_FAMILY: assert property (demod_ctrl_o.demod_options[0]
		&& demod_ctrl_o.active_std == 16'h0008 |-> demod_ctrl_o.std_family == 16'h0003)
		else $error("equivalent code not merged");
	AST_INIT_PULSE: assert property (demod_init_o |=> !demod_init_o)
		else $error("reinit longer than a cycle");

	// Main scenarios
	cover property ($fell(demod_ctrl_o.detect_busy) && demod_ctrl_o.detection_result != STD_NONE);
	cover property (scan_start_o);
	cover property (rd_byte_valid_o);
endmodule : sound_reg_monitor

bind sound_reg_interface sound_reg_monitor #(.DETECT_LIMIT(DETECT_LIMIT)) mon (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .frame_start_i(frame_start_i),
	.rd_byte_req_i(rd_byte_req_i), .rd_byte_valid_o(rd_byte_valid_o),
	.scan_start_o(scan_start_o), .demod_init_o(demod_init_o), .demod_ctrl_o(demod_ctrl_o));

// ### tb/tv_sound_register_interface_bench.sv
// Self-checking bench driving the register interface through its byte protocol
`timescale 1ns/1ns
module tv_sound_register_interface_bench;
	import sound_regs_pkg::*;
	localparam int DETECT_LIMIT = 200;
	logic ref_clk_i = 0, reset_i = 1, frame_start_i = 0, frame_stop_i = 0;
	logic wr_byte_valid_i = 0, rd_byte_req_i = 0, silent = 0, scan_done, wr_byte_ack_o;
	logic rd_byte_valid_o, scan_start_o, demod_init_o, ack_last;
	logic [7:0] wr_byte_i = 8'h00, delay = 8'h03, rd_byte_o;
	logic [15:0] code = 16'h000b, scan_code, rd_data;
	demod_ctrl_s demod_ctrl_o;
	baseband_ctrl_s baseband_ctrl_o;
	int err_total = 0, check_count = 0, init_seen = 0;
	logic [15:0] rst_addr [4] = '{16'h0000, 16'h0008, 16'h000c, 16'h0016};
	logic [15:0] rst_val [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h1000};

	initial forever #10 ref_clk_i = ~ref_clk_i;
	// Reinit pulses seen, for the one-write setup check
	always @(posedge ref_clk_i) if (demod_init_o === 1'b1) init_seen++;

	// Variant without digital stereo, so those codes must fall back to mono
	sound_reg_interface #(.DETECT_LIMIT(DETECT_LIMIT), .NICAM_OK(1'b0)) dut (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .frame_start_i(frame_start_i), .frame_stop_i(frame_stop_i),
		.wr_byte_valid_i(wr_byte_valid_i), .wr_byte_i(wr_byte_i), .wr_byte_ack_o(wr_byte_ack_o),
		.rd_byte_req_i(rd_byte_req_i), .rd_byte_o(rd_byte_o), .rd_byte_valid_o(rd_byte_valid_o),
		.scan_done_i(scan_done), .scan_code_i(scan_code), .reception_status_i(16'h0142),
		.peak_left_i(16'h8001), .peak_right_i(16'h1234), .scan_start_o(scan_start_o),
		.demod_init_o(demod_init_o), .demod_ctrl_o(demod_ctrl_o),
		.baseband_ctrl_o(baseband_ctrl_o));
	carrier_scanner_model scanner (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.scan_start_i(scan_start_o), .silent_i(silent), .delay_i(delay),
		.found_code_i(code), .scan_done_o(scan_done), .scan_code_o(scan_code));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Bytes go one per cycle with valid held high between them; ack is sampled once settled
	task automatic put(input logic [7:0] b);
		wr_byte_valid_i = 1'b1;
		wr_byte_i = b;
		#1 ack_last = wr_byte_ack_o;
		@(negedge ref_clk_i);
	endtask : put
	task automatic open_frame(input logic [7:0] sub, input logic [15:0] addr);
		frame_start_i = 1'b1;
		@(negedge ref_clk_i);
		frame_start_i = 1'b0;
		put(sub);
		put(addr[15:8]);
		put(addr[7:0]);
	endtask : open_frame
	task automatic close_frame();
		frame_stop_i = 1'b1;
		@(negedge ref_clk_i);
		frame_stop_i = 1'b0;
	endtask : close_frame
	task automatic wr_word(input logic [7:0] sub, input logic [15:0] addr, input logic [15:0] d);
		open_frame(sub, addr);
		put(d[15:8]);
		put(d[7:0]);
		wr_byte_valid_i = 1'b0;
		close_frame();
	endtask : wr_word
	task automatic get_byte(output logic [7:0] b);
		rd_byte_req_i = 1'b1;
		@(negedge ref_clk_i);
		rd_byte_req_i = 1'b0;
		check({15'h0000, rd_byte_valid_o}, 16'h0001);
		b = rd_byte_o;
		@(negedge ref_clk_i);
	endtask : get_byte
	// Upper byte arrives first, then the lower byte
	task automatic rd_check(input logic [7:0] sub, input logic [15:0] addr, input logic [15:0] e);
		open_frame(sub, addr);
		wr_byte_valid_i = 1'b0;
		frame_start_i = 1'b1;
		@(negedge ref_clk_i);
		frame_start_i = 1'b0;
		@(negedge ref_clk_i);
		get_byte(rd_data[15:8]);
		get_byte(rd_data[7:0]);
		close_frame();
		check(rd_data, e);
	endtask : rd_check
	task automatic wait_idle();
		for (int i = 0; i < 2 * DETECT_LIMIT && demod_ctrl_o.detect_busy !== 1'b0; i++)
			@(negedge ref_clk_i);
		if (demod_ctrl_o.detect_busy !== 1'b0) begin
			err_total++;
			give_verdict();
		end
	endtask : wait_idle

	initial begin
		repeat (4) @(negedge ref_clk_i);
		reset_i = 1'b0;
		check(demod_ctrl_o.demod_options, 16'h0000);
		for (int i = 0; i < 4; i++)
			rd_check(SUB_RD_BASEBAND, rst_addr[i], rst_val[i]);
		wr_word(8'h12, 16'h0008, 16'h0120);
		check(baseband_ctrl_o.speaker_route, 16'h0120);
		check({15'h0000, ack_last}, 16'h0001);
		rd_check(8'h13, 16'h0008, 16'h0120);
		wr_word(8'h13, 16'h0000, 16'h5555);
		check({15'h0000, ack_last}, 16'h0000);
		rd_check(8'h13, 16'h0000, 16'h0000);
		wr_word(8'h12, 16'h001e, 16'hffff);
		rd_check(8'h13, 16'h001e, HW_VERSION_ID);
		rd_check(8'h13, 16'h001f, PRODUCT_ROM_ID);
		rd_check(8'h13, 16'h0029, 16'h0000);
		rd_check(8'h13, 16'h0019, 16'h0000);
		rd_check(8'h13, 16'h001a, 16'h1234);
		wr_word(8'h10, 16'h0040, 16'h0001);
		check(demod_ctrl_o.serial_audio_config, 16'h0001);
		rd_check(8'h11, 16'h0040, 16'h0000);
		rd_check(8'h11, 16'h0200, 16'h0142);
		wr_word(8'h10, 16'h0030, 16'h0001);
		init_seen = 0;
		wr_word(8'h10, 16'h0020, 16'h0008);
		check(demod_ctrl_o.active_std, 16'h0008);
		check(demod_ctrl_o.std_family, 16'h0003);
		check(16'(init_seen), 16'h0001);
		check({15'h0000, demod_ctrl_o.stereo_allowed}, 16'h0000);
		wr_word(8'h10, 16'h0020, 16'h0005);
		check(demod_ctrl_o.std_family, 16'h0004);
		check({15'h0000, demod_ctrl_o.stereo_allowed}, 16'h0001);
		// Speaker volume muted before detection, then a prompt answer from the scanner
		wr_word(8'h12, 16'h0000, 16'h0000);
		check(baseband_ctrl_o.speaker_volume, 16'h0000);
		wr_word(8'h10, 16'h0020, STD_AUTO);
		wait_idle();
		rd_check(8'h11, 16'h007e, 16'h000b);
		check(demod_ctrl_o.active_std, 16'h000b);
		check(demod_ctrl_o.std_family, 16'h0004);
		// Slow answer with a code detection must not report
		delay = 8'h3c;
		code = 16'h000c;
		wr_word(8'h10, 16'h0020, STD_AUTO);
		rd_check(8'h11, 16'h007e, STD_BUSY);
		wr_word(8'h10, 16'h0030, 16'h0000);
		wait_idle();
		check(demod_ctrl_o.demod_options, 16'h0001);
		rd_check(8'h11, 16'h007e, 16'h0000);
		// Scanner never answers, so the time limit ends the run
		silent = 1'b1;
		wr_word(8'h10, 16'h0020, STD_AUTO);
		wait_idle();
		rd_check(8'h11, 16'h007e, 16'h0000);
		give_verdict();
	end
endmodule : tv_sound_register_interface_bench
